//--- verilog/mcor_pkg.sv
// package for the core operating register bank: addresses, fields, resets, timing
// assumes one core clock, registers reached from the cpu instruction stream
package mcor_pkg;
  localparam logic [7:0] ADDR_INDIRECT  = 8'h00;
  localparam logic [7:0] ADDR_TIMER     = 8'h01;
  localparam logic [7:0] ADDR_PC_LOW    = 8'h02;
  localparam logic [7:0] ADDR_STATUS    = 8'h03;
  localparam logic [7:0] ADDR_RAM_PTR   = 8'h04;
  localparam logic [7:0] ADDR_SYS_CTRL  = 8'h05;
  localparam logic [7:0] ADDR_PORT_A    = 8'h06;
  localparam logic [7:0] ADDR_PORT_B    = 8'h07;
  localparam logic [7:0] ADDR_PORT_C    = 8'h08;
  localparam logic [7:0] ADDR_PORT_D    = 8'h09;
  localparam logic [7:0] ADDR_T4_CTRL   = 8'h0B;
  localparam logic [7:0] ADDR_T4_DATA   = 8'h0C;
  localparam logic [7:0] ADDR_BANK_LO   = 8'h05;
  localparam logic [7:0] ADDR_BANK_HI   = 8'h0F;
  localparam logic [7:0] ADDR_GP_LO     = 8'h20;
  localparam logic [7:0] ADDR_GP_HI     = 8'h3F;
  // status fields
  localparam int ST_BANK_HI = 7;
  localparam int ST_BANK_LO = 6;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_PWRDN   = 3;
  localparam int ST_ZERO    = 2;
  localparam int ST_AUXC    = 1;
  localparam int ST_CARRY   = 0;
  localparam logic [7:0] ST_RESET   = 8'h18;
  localparam logic [7:0] ST_RW_MASK = 8'hC7;
  // system control fields
  localparam int SC_PAGE_HI = 6;
  localparam int SC_PAGE_LO = 4;
  localparam int SC_SIS     = 1;
  localparam int SC_REM     = 0;
  localparam logic [7:0] SC_RW_MASK = 8'h73;
  localparam logic [7:0] SC_FIXED   = 8'h04;
  localparam logic [7:0] SC_RESET   = 8'h04;
  localparam logic [7:0] PORT_B_MASK = 8'h0F;
  localparam logic [7:0] PORT_C_MASK = 8'h03;
  localparam logic [1:0] FF_CLEAR  = 2'h0;
  localparam logic [1:0] FF_TOGGLE = 2'h1;
  localparam logic [1:0] FF_SET    = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_PDO   = 2'h2;
  localparam logic [1:0] MODE_PWM   = 2'h3;
  localparam logic [2:0] CK_EXTERNAL = 3'h7;
  localparam int PC_LOW_W  = 10;
  localparam int PC_W      = 13;
  localparam logic [9:0] PC_RESET = 10'h000;
  localparam int PRESC_W   = 11;
  typedef enum logic [2:0] {
    MCOR_RUN   = 3'b001,
    MCOR_STALL = 3'b010,
    MCOR_LOWP  = 3'b100
  } mcor_state_t;
endpackage : mcor_pkg

//--- verilog/mcor_regs.sv
// core operating register bank with pc, stack, status and timer-4 control
// assumes an instruction decoder presenting one decoded op per cycle as pulses
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - address zero accesses the location held by the ram select pointer
// - main timer read/write; prescaler cleared by reset or a timer write
// - pc spans 8192 words, organised as 1024-word pages
// - call loads low ten pc bits and pushes pc plus one
// - returns pop the stack; return and return_with_literal leave page select untouched
// - pc-changing instructions take one extra cycle
// - interrupt vectors in page 0, saves acc status page, return_from_interrupt restores
// - status bits 7:6 choose special bank for 05h to 0Fh
// - timeout flag set by sleep, watchdog clear, power-up; cleared on timeout
// - power-down flag set at power-on or watchdog clear; cleared by sleep
// - zero flag set on zero result; bits 1,0 aux carry and carry
// - pointer bits 7:6 choose gp bank for 20h to 3Fh; bank op sets them
// - pointer low six bits give indirect address; else plain storage
// - pc writes copy page select into the top three pc bits
// - sleep idle select: zero idle, one sleep
// - wake release: zero rising edge, one high level
// - ports at 06h to 09h; narrow ports read upper bits zero
// - output flip-flop control: clear, toggle, set, reserved
// - run bit zero stops and clears counter; one starts
// - clock select picks prescaler taps, the undivided core clock or external pin
module mcor_regs
  import mcor_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int SP_W        = 3
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // register access from the instruction stream
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // alu results
  input  wire logic        alu_valid,
  input  wire logic        alu_arith,
  input  wire logic [7:0]  alu_result,
  input  wire logic        alu_carry,
  input  wire logic        alu_aux_carry,
  input  wire logic [7:0]  acc_in,
  output logic      [7:0]  acc_restore,
  output logic             acc_restore_valid,
  // control flow
  input  wire logic        jump_op,
  input  wire logic        call_op,
  input  wire logic        return_op,
  input  wire logic        return_with_literal,
  input  wire logic        return_from_interrupt,
  input  wire logic [9:0]  target_addr,
  input  wire logic        irq_take,
  input  wire logic [9:0]  irq_vector,
  input  wire logic        bank_op,
  input  wire logic [1:0]  bank_value,
  input  wire logic        page_op,
  input  wire logic [2:0]  page_value,
  input  wire logic        sleep_instruction,
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        watchdog_timeout,
  input  wire logic        next_instr,
  output logic      [12:0] prog_addr,
  output logic             stall,
  // ram and special banks
  output logic      [7:0]  data_addr,
  output logic      [1:0]  special_bank_select,
  output logic      [1:0]  gp_bank_select,
  // ports: direction comes from outside
  input  wire logic [7:0]  port_a_direction,
  input  wire logic [7:0]  port_b_direction,
  input  wire logic [7:0]  port_c_direction,
  input  wire logic [7:0]  port_d_direction,
  input  wire logic [7:0]  port_a_pin,
  input  wire logic [7:0]  port_b_pin,
  input  wire logic [7:0]  port_c_pin,
  input  wire logic [7:0]  port_d_pin,
  output logic      [7:0]  port_a_out,
  output logic      [7:0]  port_b_out,
  output logic      [7:0]  port_c_out,
  output logic      [7:0]  port_d_out,
  output logic      [7:0]  port_a_oe,
  output logic      [7:0]  port_b_oe,
  output logic      [7:0]  port_c_oe,
  output logic      [7:0]  port_d_oe,
  // low power and timer pins
  input  wire logic        wake_pin,
  input  wire logic        t4_external_clock_pin,
  output logic             low_power,
  output logic             sleep_mode,
  output logic             wake_release,
  output logic             t4_tick,
  output logic             t4_output,
  output logic      [1:0]  t4_mode_select,
  output logic      [7:0]  main_timer_counter,
  output logic      [7:0]  t4_data
);

  logic [9:0]  pc_reg;
  logic [7:0]  status_reg;
  logic [7:0]  ram_ptr_reg;
  logic [7:0]  sysctl_reg;
  logic [7:0]  timer_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic [7:0]  port_reg [4];
  logic [7:0]  t4ctl_reg;
  logic [7:0]  t4data_reg;
  logic [7:0]  t4cnt_reg;
  logic        t4ff_reg;
  logic [9:0]  stack_reg [STACK_DEPTH];
  logic [SP_W-1:0] sp_reg;
  logic [7:0]  save_acc_reg;
  logic [7:0]  save_st_reg;
  logic [2:0]  save_pg_reg;
  mcor_state_t state_reg;
  logic [1:0]  wake_sync_reg;
  logic        wake_prev_reg;
  logic [1:0]  ext_sync_reg;
  logic        ext_prev_reg;
  logic [7:0]  pin_a_reg [2];
  logic [7:0]  pin_b_reg [2];
  logic [7:0]  pin_c_reg [2];
  logic [7:0]  pin_d_reg [2];

  logic [7:0]  eff_addr;
  logic        wr_stat;
  logic        any_ret;
  logic        pc_write;
  logic [9:0]  top_entry;
  logic        t4_src;
  logic        ext_edge;
  logic        wake_ok;

  // address zero is only a window onto the pointed location
  assign eff_addr  = (reg_addr == ADDR_INDIRECT) ? {2'h0, ram_ptr_reg[5:0]} : reg_addr;
  assign wr_stat   = reg_wr && eff_addr == ADDR_STATUS;
  assign any_ret   = return_op || return_with_literal || return_from_interrupt;
  assign pc_write  = jump_op || call_op || (reg_wr && eff_addr == ADDR_PC_LOW);
  assign top_entry = stack_reg[sp_reg - SP_W'(1)];
  assign ext_edge  = ext_sync_reg[1] && !ext_prev_reg;
  assign wake_ok   = sysctl_reg[SC_REM] ? wake_sync_reg[1]
                                        : (wake_sync_reg[1] && !wake_prev_reg);

  // pin synchronisers
  always_ff @(posedge core_clk) begin
    wake_sync_reg <= {wake_sync_reg[0], wake_pin};
    wake_prev_reg <= wake_sync_reg[1];
    ext_sync_reg  <= {ext_sync_reg[0], t4_external_clock_pin};
    ext_prev_reg  <= ext_sync_reg[1];
    pin_a_reg[0]  <= port_a_pin;
    pin_a_reg[1]  <= pin_a_reg[0];
    pin_b_reg[0]  <= port_b_pin;
    pin_b_reg[1]  <= pin_b_reg[0];
    pin_c_reg[0]  <= port_c_pin;
    pin_c_reg[1]  <= pin_c_reg[0];
    pin_d_reg[0]  <= port_d_pin;
    pin_d_reg[1]  <= pin_d_reg[0];
  end

  // program counter, stack and interrupt save
  always_ff @(posedge core_clk) begin
    acc_restore_valid <= 1'b0;
    if (sys_rst) begin
      pc_reg       <= PC_RESET;
      sp_reg       <= '0;
      save_acc_reg <= 8'h00;
      save_st_reg  <= 8'h00;
      save_pg_reg  <= 3'h0;
      acc_restore  <= 8'h00;
    end else if (irq_take) begin
      stack_reg[sp_reg] <= pc_reg;
      sp_reg       <= sp_reg + SP_W'(1);
      pc_reg       <= irq_vector;
      save_acc_reg <= acc_in;
      save_st_reg  <= status_reg;
      save_pg_reg  <= sysctl_reg[SC_PAGE_HI:SC_PAGE_LO];
    end else if (call_op) begin
      stack_reg[sp_reg] <= pc_reg + 10'h001;
      sp_reg       <= sp_reg + SP_W'(1);
      pc_reg       <= target_addr;
    end else if (any_ret) begin
      pc_reg       <= top_entry;
      sp_reg       <= sp_reg - SP_W'(1);
      if (return_from_interrupt) begin
        acc_restore       <= save_acc_reg;
        acc_restore_valid <= 1'b1;
      end
    end else if (jump_op) begin
      pc_reg <= target_addr;
    end else if (reg_wr && eff_addr == ADDR_PC_LOW) begin
      pc_reg <= {2'h0, reg_wdata};
    end else if (next_instr && state_reg == MCOR_RUN) begin
      pc_reg <= pc_reg + 10'h001;
    end
  end

  // page copied into the top bits when the pc is written
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prog_addr <= 13'h0000;
    end else if (irq_take) begin
      prog_addr <= {3'h0, irq_vector};
    end else if (pc_write) begin
      prog_addr <= {sysctl_reg[SC_PAGE_HI:SC_PAGE_LO],
                    call_op || jump_op ? target_addr : {2'h0, reg_wdata}};
    end else if (any_ret) begin
      prog_addr <= {prog_addr[12:10], top_entry};
    end else begin
      prog_addr <= {prog_addr[12:10], pc_reg};
    end
  end

  // extra cycle after flow change, low power hold
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= MCOR_RUN;
    end else begin
      unique case (state_reg)
        MCOR_RUN: begin
          if (sleep_instruction) state_reg <= MCOR_LOWP;
          else if (pc_write || any_ret || irq_take) state_reg <= MCOR_STALL;
        end
        MCOR_STALL: state_reg <= MCOR_RUN;
        MCOR_LOWP:  if (wake_ok) state_reg <= MCOR_RUN;
        default:    state_reg <= MCOR_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    stall     <= !sys_rst && state_reg != MCOR_RUN;
    low_power <= !sys_rst && state_reg == MCOR_LOWP;
  end

  // status: hardware sets win over software writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_reg <= ST_RESET;
    end else if (return_from_interrupt) begin
      status_reg <= save_st_reg;
    end else begin
      if (wr_stat) status_reg <= (reg_wdata & ST_RW_MASK) | (status_reg & ~ST_RW_MASK);
      if (alu_valid) begin
        status_reg[ST_ZERO] <= alu_result == 8'h00;
        if (alu_arith) begin
          status_reg[ST_CARRY] <= alu_carry;
          status_reg[ST_AUXC]  <= alu_aux_carry;
        end
      end
      if (watchdog_timeout) status_reg[ST_TIMEOUT] <= 1'b0;
      if (sleep_instruction) begin
        status_reg[ST_TIMEOUT] <= 1'b1;
        status_reg[ST_PWRDN]   <= 1'b0;
      end
      if (watchdog_clear_instruction) begin
        status_reg[ST_TIMEOUT] <= 1'b1;
        status_reg[ST_PWRDN]   <= 1'b1;
      end
    end
  end

  // pointer and system control
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ram_ptr_reg <= 8'h00;
      sysctl_reg  <= SC_RESET;
    end else begin
      if (reg_wr && eff_addr == ADDR_RAM_PTR) ram_ptr_reg <= reg_wdata;
      if (bank_op) ram_ptr_reg[7:6] <= bank_value;
      if (reg_wr && eff_addr == ADDR_SYS_CTRL && status_reg[7:6] == 2'h0)
        sysctl_reg <= (reg_wdata & SC_RW_MASK) | SC_FIXED;
      if (page_op) sysctl_reg[SC_PAGE_HI:SC_PAGE_LO] <= page_value;
      if (return_from_interrupt) sysctl_reg[SC_PAGE_HI:SC_PAGE_LO] <= save_pg_reg;
    end
  end

  // main timer; prescaler runs on the core clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timer_reg <= 8'h00;
      presc_reg <= '0;
    end else if (reg_wr && eff_addr == ADDR_TIMER) begin
      timer_reg <= reg_wdata;
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + PRESC_W'(1);
    end
  end

  // ports and timer-4 registers written in special bank 0 only; reads ignore the bank
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) port_reg[i] <= 8'h00;
      t4ctl_reg  <= 8'h00;
      t4data_reg <= 8'h00;
    end else if (reg_wr && status_reg[7:6] == 2'h0) begin
      unique case (eff_addr)
        ADDR_PORT_A:  port_reg[0] <= reg_wdata;
        ADDR_PORT_B:  port_reg[1] <= reg_wdata & PORT_B_MASK;
        ADDR_PORT_C:  port_reg[2] <= reg_wdata & PORT_C_MASK;
        ADDR_PORT_D:  port_reg[3] <= reg_wdata;
        ADDR_T4_CTRL: t4ctl_reg   <= reg_wdata;
        ADDR_T4_DATA: t4data_reg  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // timer-4 tick source from prescaler taps, the core clock or the external pin edge
  always_comb begin
    unique case (t4ctl_reg[4:2])
      3'h0:    t4_src = presc_reg[10] && presc_reg[9:0] == 10'h000;
      3'h1:    t4_src = presc_reg[6:0] == 7'h00;
      3'h2:    t4_src = presc_reg[4:0] == 5'h00;
      3'h3:    t4_src = presc_reg[2:0] == 3'h0;
      3'h4:    t4_src = presc_reg[1:0] == 2'h0;
      3'h5:    t4_src = presc_reg[0];
      3'h6:    t4_src = 1'b1;
      default: t4_src = ext_edge;
    endcase
  end

  // counter t4cnt_reg counts source ticks here; run bit low clears it and the tick
  always_ff @(posedge core_clk) begin
    if (sys_rst || !t4ctl_reg[5]) begin
      t4cnt_reg <= 8'h00;
      t4_tick   <= 1'b0;
    end else begin
      t4cnt_reg <= t4cnt_reg + {7'h00, t4_src};
      t4_tick   <= t4_src;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      t4ff_reg <= 1'b0;
    end else if (t4_tick && t4ctl_reg[1:0] != 2'h1) begin
      unique case (t4ctl_reg[7:6])
        FF_CLEAR:  t4ff_reg <= 1'b0;
        FF_TOGGLE: t4ff_reg <= !t4ff_reg;
        FF_SET:    t4ff_reg <= 1'b1;
        default:   t4ff_reg <= t4ff_reg;
      endcase
    end
  end

  // read mux, registered
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (eff_addr)
        ADDR_TIMER:    reg_rdata <= timer_reg;
        ADDR_PC_LOW:   reg_rdata <= pc_reg[7:0];
        ADDR_STATUS:   reg_rdata <= status_reg & 8'hDF;
        ADDR_RAM_PTR:  reg_rdata <= ram_ptr_reg;
        ADDR_SYS_CTRL: reg_rdata <= sysctl_reg;
        ADDR_PORT_A:   reg_rdata <= (port_reg[0] & port_a_direction) | (pin_a_reg[1] & ~port_a_direction);
        ADDR_PORT_B:   reg_rdata <= ((port_reg[1] & port_b_direction) | (pin_b_reg[1] & ~port_b_direction)) & PORT_B_MASK;
        ADDR_PORT_C:   reg_rdata <= ((port_reg[2] & port_c_direction) | (pin_c_reg[1] & ~port_c_direction)) & PORT_C_MASK;
        ADDR_PORT_D:   reg_rdata <= (port_reg[3] & port_d_direction) | (pin_d_reg[1] & ~port_d_direction);
        ADDR_T4_CTRL:  reg_rdata <= t4ctl_reg;
        ADDR_T4_DATA:  reg_rdata <= t4data_reg;
        default:       reg_rdata <= 8'h00;
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge core_clk) begin
    data_addr           <= sys_rst ? 8'h00 : eff_addr;
    special_bank_select <= sys_rst ? 2'h0 : status_reg[ST_BANK_HI:ST_BANK_LO];
    gp_bank_select      <= sys_rst ? 2'h0 : ram_ptr_reg[7:6];
    sleep_mode          <= sys_rst ? 1'b0 : sysctl_reg[SC_SIS];
    wake_release        <= sys_rst ? 1'b0 : (state_reg == MCOR_LOWP && wake_ok);
    t4_output           <= sys_rst ? 1'b0 : t4ff_reg;
    t4_mode_select      <= sys_rst ? 2'h0 : t4ctl_reg[1:0];
    main_timer_counter  <= sys_rst ? 8'h00 : timer_reg;
    t4_data             <= sys_rst ? 8'h00 : t4data_reg;
    port_a_out          <= sys_rst ? 8'h00 : port_reg[0];
    port_b_out          <= sys_rst ? 8'h00 : port_reg[1];
    port_c_out          <= sys_rst ? 8'h00 : port_reg[2];
    port_d_out          <= sys_rst ? 8'h00 : port_reg[3];
    port_a_oe           <= sys_rst ? 8'h00 : port_a_direction;
    port_b_oe           <= sys_rst ? 8'h00 : port_b_direction & PORT_B_MASK;
    port_c_oe           <= sys_rst ? 8'h00 : port_c_direction & PORT_C_MASK;
    port_d_oe           <= sys_rst ? 8'h00 : port_d_direction;
  end

endmodule // mcor_regs
`default_nettype wire

//--- tb/mcor_regs_assertions.sv
// checker for the core operating register bank, top ports only
// assumes a bind onto mcor_regs, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module mcor_regs_assertions
  import mcor_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // requests seen
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        jump_op,
  input wire logic        call_op,
  input wire logic        return_op,
  input wire logic [9:0]  target_addr,
  input wire logic        irq_take,
  input wire logic [9:0]  irq_vector,
  input wire logic        bank_op,
  input wire logic [1:0]  bank_value,
  // design outputs
  input wire logic [7:0]  reg_rdata,
  input wire logic [12:0] prog_addr,
  input wire logic        stall,
  input wire logic [1:0]  special_bank_select,
  input wire logic [1:0]  gp_bank_select,
  input wire logic        sleep_mode,
  input wire logic [1:0]  t4_mode_select
);
  logic [7:0] wdata_q;
  logic [9:0] target_q;
  logic [9:0] vector_q;
  logic [1:0] bank_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // last request, kept for checks a few cycles on
  always_ff @(posedge core_clk) begin
    if (reg_wr) wdata_q <= reg_wdata;
    if (call_op) target_q <= target_addr;
    if (irq_take) vector_q <= irq_vector;
    if (bank_op) bank_q <= bank_value;
  end
  pc_reset_a: assert property (disable iff (1'b0) $fell(sys_rst) |-> prog_addr == 13'h0000)
    else $error("pc not cleared by reset");
  flow_stall_a: assert property ((jump_op || call_op || return_op) |-> ##[1:2] stall)
    else $error("no extra cycle after pc change");
  call_target_a: assert property (call_op && !irq_take |-> ##[1:3] prog_addr[9:0] == target_q)
    else $error("call target not loaded");
  irq_vector_a: assert property (irq_take |-> ##[1:3] prog_addr == {3'h0, vector_q})
    else $error("interrupt vector not in page 0");
  special_bank_a: assert property (reg_wr && reg_addr == ADDR_STATUS
    |-> ##[1:2] special_bank_select == wdata_q[7:6]) else $error("special bank not taken");
  gp_bank_a: assert property (bank_op |-> ##[1:2] gp_bank_select == bank_q)
    else $error("gp bank not taken");
  sleep_sel_a: assert property (reg_wr && reg_addr == ADDR_SYS_CTRL && special_bank_select == 2'h0
    |-> ##[1:2] sleep_mode == wdata_q[SC_SIS]) else $error("sleep select not taken");
  t4_mode_a: assert property (reg_wr && reg_addr == ADDR_T4_CTRL && special_bank_select == 2'h0
    |-> ##[1:2] t4_mode_select == wdata_q[1:0]) else $error("timer mode not taken");
  port_b_zero_a: assert property (!reg_wr && reg_addr == ADDR_PORT_B && special_bank_select == 2'h0
    |=> reg_rdata[7:4] == 4'h0) else $error("port b upper bits not zero");
  port_c_zero_a: assert property (!reg_wr && reg_addr == ADDR_PORT_C && special_bank_select == 2'h0
    |=> reg_rdata[7:2] == 6'h00) else $error("port c upper bits not zero");
endmodule // mcor_regs_assertions
bind mcor_regs mcor_regs_assertions u_mcor_regs_assertions (.*);
`default_nettype wire

//--- tb/mcor_regs_bench.sv
// self-checking bench for the core operating register bank
// assumes mcor_regs with its checker bound in, one 100 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module mcor_regs_bench import mcor_pkg::*;;
  localparam int JMP = 0, CALL = 1, RET = 2, RETURN_WITH_LITERAL = 3, RETURN_FROM_INTERRUPT = 4, IRQ = 5, BANK = 6;
  localparam int PAGE = 7, SLP = 8, WDC = 9, WTO = 10, ALU = 11, NXT = 12;
  // stimulus
  logic        core_clk, sys_rst, reg_wr, alu_arith, alu_carry, alu_aux_carry;
  logic        wake_pin, t4_external_clock_pin;
  logic [7:0]  reg_addr, reg_wdata, alu_result, acc_in;
  logic [9:0]  target_addr, irq_vector;
  logic [1:0]  bank_value;
  logic [2:0]  page_value;
  logic [12:0] ops;
  logic [7:0]  port_a_direction, port_b_direction, port_c_direction, port_d_direction;
  logic [7:0]  port_a_pin, port_b_pin, port_c_pin, port_d_pin;
  logic        jump_op, call_op, return_op, return_with_literal, return_from_interrupt;
  logic        irq_take, bank_op, page_op, sleep_instruction, watchdog_clear_instruction;
  logic        watchdog_timeout, alu_valid, next_instr;
  // observed
  logic [7:0]  reg_rdata, acc_restore, data_addr, t4_data, main_timer_counter;
  logic [7:0]  port_a_out, port_b_out, port_c_out, port_d_out;
  logic [7:0]  port_a_oe, port_b_oe, port_c_oe, port_d_oe;
  logic [12:0] prog_addr;
  logic [1:0]  special_bank_select, gp_bank_select, t4_mode_select;
  logic        acc_restore_valid, stall, low_power, sleep_mode, wake_release;
  logic        t4_tick, t4_output;
  int          error_cnt, cmp_count, n;
  logic [7:0]  rv;
  // one-hot pulses, so one task drives any op
  assign {next_instr, alu_valid, watchdog_timeout, watchdog_clear_instruction,
          sleep_instruction, page_op, bank_op, irq_take, return_from_interrupt,
          return_with_literal, return_op, call_op, jump_op} = ops;
  mcor_regs u_mcor_regs (.*);
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    tick(2);
    d = reg_rdata;
  endtask
  // v feeds every op field at once
  task automatic op(input int b, input logic [10:0] v);
    @(posedge core_clk);
    ops <= 13'h1 << b;
    {target_addr, irq_vector, acc_in, alu_result} <= {v[9:0], v[9:0], v[7:0], v[7:0]};
    {bank_value, page_value, alu_carry, alu_aux_carry, alu_arith} <= {v[1:0], v[2:0], v[10:8]};
    @(posedge core_clk);
    ops <= '0;
  endtask
  task automatic wait_lp(input logic v, input string what);
    for (n = 0; low_power !== v && n < 40; n++) tick(1);
    check(what, low_power, v);
  endtask
  task automatic count_ticks(output int c);
    c = 0;
    repeat (600) begin
      tick(1);
      c += int'(t4_tick === 1'b1);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial begin
    {sys_rst, reg_wr, alu_arith, alu_carry, alu_aux_carry, wake_pin, t4_external_clock_pin} = 7'h40;
    {reg_addr, reg_wdata, alu_result, acc_in, target_addr, irq_vector, bank_value, page_value} = '0;
    {port_a_direction, port_b_direction, port_c_direction, port_d_direction} = '0;
    {port_a_pin, port_b_pin, port_c_pin, port_d_pin} = '0;
    ops = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(ADDR_STATUS, rv);
    check("status reset", rv, ST_RESET);
    rd(ADDR_SYS_CTRL, rv);
    check("control reset", rv, SC_RESET);
    check("pc reset", prog_addr, 13'h0000);
    op(NXT, 11'h0);
    tick(3);
    check("pc step", prog_addr, 13'h0001);
    $display("test reset done");
    wr(ADDR_T4_DATA, 8'h5A);
    wr(ADDR_RAM_PTR, 8'h0C);
    rd(ADDR_INDIRECT, rv);
    check("indirect read", rv, 8'h5A);
    check("effective address", data_addr, 8'h0C);
    wr(ADDR_INDIRECT, 8'hC3);
    rd(ADDR_T4_DATA, rv);
    check("indirect write", {rv, t4_data}, 16'hC3C3);
    op(BANK, 11'h2);
    rd(ADDR_RAM_PTR, rv);
    check("pointer", rv, 8'h8C);
    check("gp bank", gp_bank_select, 2'h2);
    wr(ADDR_TIMER, 8'hA5);
    rd(ADDR_TIMER, rv);
    check("timer read", rv, 8'hA5);
    check("timer value", main_timer_counter, 8'hA5);
    $display("test pointer and timer done");
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, rv);
    check("status write", rv, 8'hDF);
    check("special bank", special_bank_select, 2'h3);
    wr(ADDR_SYS_CTRL, 8'h03);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_SYS_CTRL, rv);
    check("other bank write", rv, SC_RESET);
    op(ALU, 11'h500);
    rd(ADDR_STATUS, rv);
    check("zero and carry", rv, 8'h1D);
    op(ALU, 11'h312);
    rd(ADDR_STATUS, rv);
    check("aux carry", rv, 8'h1A);
    op(ALU, 11'h000);
    rd(ADDR_STATUS, rv);
    check("logic zero", rv, 8'h1E);
    op(WTO, 11'h0);
    rd(ADDR_STATUS, rv);
    check("timeout clear", rv, 8'h0E);
    op(WDC, 11'h0);
    rd(ADDR_STATUS, rv);
    check("watchdog clear", rv, 8'h1E);
    $display("test status done");
    wr(ADDR_SYS_CTRL, 8'h01);
    tick(3);
    check("idle select", sleep_mode, 1'b0);
    op(SLP, 11'h0);
    wait_lp(1'b1, "enter idle");
    tick(10);
    check("held in idle", low_power, 1'b1);
    @(posedge core_clk);
    wake_pin <= 1'b1;
    wait_lp(1'b0, "level release");
    rd(ADDR_STATUS, rv);
    check("sleep flags", rv, 8'h16);
    wr(ADDR_SYS_CTRL, 8'h02);
    tick(3);
    check("sleep select", sleep_mode, 1'b1);
    op(SLP, 11'h0);
    wait_lp(1'b1, "enter sleep");
    tick(10);
    check("high pin no edge", low_power, 1'b1);
    @(posedge core_clk);
    wake_pin <= 1'b0;
    tick(5);
    wake_pin <= 1'b1;
    wait_lp(1'b0, "edge release");
    $display("test low power done");
    op(PAGE, 11'h5);
    rd(ADDR_SYS_CTRL, rv);
    check("page field", rv, 8'h56);
    op(JMP, 11'h123);
    tick(3);
    check("jump", prog_addr, 13'h1523);
    op(CALL, 11'h200);
    tick(3);
    check("call", prog_addr, 13'h1600);
    op(RET, 11'h0);
    tick(3);
    check("return", prog_addr, 13'h1524);
    op(PAGE, 11'h7);
    op(JMP, 11'h3FF);
    tick(3);
    check("top word", prog_addr, 13'h1FFF);
    op(CALL, 11'h010);
    op(RETURN_WITH_LITERAL, 11'h0);
    tick(3);
    check("ten bit return", prog_addr, 13'h1C00);
    rd(ADDR_SYS_CTRL, rv);
    check("page kept", rv, 8'h76);
    op(IRQ, 11'h077);
    tick(3);
    check("vector", prog_addr, 13'h0077);
    op(PAGE, 11'h2);
    wr(ADDR_STATUS, 8'h00);
    op(RETURN_FROM_INTERRUPT, 11'h0);
    #1;
    check("acc restore", {acc_restore_valid, acc_restore}, 16'h0177);
    rd(ADDR_STATUS, rv);
    check("status restore", rv, 8'h16);
    rd(ADDR_SYS_CTRL, rv);
    check("page restore", rv, 8'h76);
    $display("test flow done");
    @(posedge core_clk);
    {port_a_direction, port_b_direction, port_c_direction, port_d_direction} <= {8'hFF, 24'h0};
    {port_a_pin, port_b_pin, port_c_pin, port_d_pin} <= {4{8'hFF}};
    wr(ADDR_PORT_A, 8'hA5);
    tick(3);
    check("port a out", port_a_out, 8'hA5);
    check("port a enable", port_a_oe, 8'hFF);
    rd(ADDR_PORT_B, rv);
    check("port b", rv, 8'h0F);
    rd(ADDR_PORT_C, rv);
    check("port c", rv, 8'h03);
    rd(ADDR_PORT_D, rv);
    check("port d", rv, 8'hFF);
    $display("test ports done");
    wr(ADDR_T4_CTRL, 8'hBA);
    tick(3);
    check("ff set", t4_output, 1'b1);
    check("divider mode", t4_mode_select, MODE_PDO);
    wr(ADDR_T4_CTRL, 8'h3B);
    tick(3);
    check("ff clear", t4_output, 1'b0);
    wr(ADDR_T4_CTRL, 8'hB9);
    rd(ADDR_T4_CTRL, rv);
    check("reserved mode", {rv, 7'h00, t4_output}, 16'hB900);
    wr(ADDR_T4_CTRL, 8'h2C);
    count_ticks(n);
    check("running", n, 16'h004B);
    wr(ADDR_T4_CTRL, 8'h18);
    tick(2);
    count_ticks(n);
    check("stopped", n, 16'h0);
    $display("test timer four done");
    final_report();
  end
endmodule // mcor_regs_bench
`default_nettype wire
